/* shared/sdc_pkg.sv */
// Constants, register map and state encodings for the SDRAM command/state core.
// Assumes one 40 MHz system clock and an AXI4-Lite master for the registers.
package sdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TRCD_NS       = 20;
  localparam int TRP_NS        = 20;
  localparam int REFRESH_RECOVERY_TIME_NS       = 70;
  // Least times round up to whole cycles
  localparam logic [3:0] TRCD_CYC = 4'((TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] TRP_CYC  = 4'((TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REFRESH_RECOVERY_TIME_CYC = 8'((REFRESH_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MRS_HOLD_CYC = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and fields
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TIMING = 8'h08;
  localparam logic [7:0] ADDR_ERROR  = 8'h0c;
  localparam int TIM_TRCD_LSB = 0;
  localparam int TIM_TRP_LSB  = 4;
  localparam int TIM_REFRESH_RECOVERY_TIME_LSB = 8;
  localparam int ST_BURST_BIT = 3;
  localparam int ST_SUSP_BIT  = 4;
  localparam int ST_BANK_LSB  = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Mode word layout
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int AP_BIT      = 10;
  localparam logic [11:0] MODE_RST = 12'h020;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_3    = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // States
  typedef enum logic [2:0] {
    G_NORM   = 3'b000,
    G_PDOWN  = 3'b001,
    G_SREF   = 3'b010,
    G_SREXIT = 3'b011,
    G_MRS    = 3'b100,
    G_REF    = 3'b101
  } sdc_gst_t;

  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_ACTV = 3'b001,
    B_ROW  = 3'b010,
    B_RD   = 3'b011,
    B_WR   = 3'b100,
    B_RDAP = 3'b101,
    B_WRAP = 3'b110,
    B_PRE  = 3'b111
  } sdc_bst_t;

endpackage

/* src/sdc_core.sv */
// Device-side command decoder, per-bank state tracker, burst engine and
// small data store of a four-bank SDRAM, with an AXI4-Lite status port.
// Assumes pins come from another domain and are synchronised here; aclk
// stands for the memory clock and every pin sees two cycles of latency.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

module sdc_core
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Memory pins
  input  wire logic        sd_cke,
  input  wire logic        sd_cs_n,
  input  wire logic        sd_ras_n,
  input  wire logic        sd_cas_n,
  input  wire logic        sd_we_n,
  input  wire logic [1:0]  sd_ba,
  input  wire logic [11:0] sd_addr,
  input  wire logic        sd_dqm,
  input  wire logic [15:0] sd_dq_i,
  output logic [15:0]      sd_dq_o,
  output logic             sd_dq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [35:0] pin_meta;
  logic [35:0] pin_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 36'h0_0000_001e;
      pin_s    <= 36'h0_0000_001e;
    end else begin
      pin_meta <= {sd_dq_i, sd_dqm, sd_addr, sd_ba, sd_we_n, sd_cas_n, sd_ras_n, sd_cs_n,
                   sd_cke};
      pin_s    <= pin_meta;
    end
  end

  wire        cke_s  = pin_s[0];
  wire        cs_n   = pin_s[1];
  wire        ras_n  = pin_s[2];
  wire        cas_n  = pin_s[3];
  wire        we_n   = pin_s[4];
  wire [1:0]  ba     = pin_s[6:5];
  wire [11:0] addr   = pin_s[18:7];
  wire        dqm_s  = pin_s[19];
  wire [15:0] dq_s   = pin_s[35:20];

  ////////////////////////////////////////////////////////////////////////////
  // State
  sdc_gst_t    gst;
  sdc_bst_t    bank_st [4];
  logic [7:0]  btmr    [4];
  logic [7:0]  gtmr;
  logic        cke_prev;
  logic [11:0] mode;
  logic [15:0] timing;
  logic [15:0] err_cnt;
  logic [15:0] mem [0:1023];
  logic        b_on;
  logic        b_rd;
  logic        b_ap;
  logic [1:0]  b_bank;
  logic [7:0]  b_base;
  logic [7:0]  b_cnt;
  logic [7:0]  b_len;
  logic        b_full;
  logic [1:0]  pv;
  logic [15:0] pd [2];
  logic        dqm_d1;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire clk_on    = cke_prev;
  wire both_high = cke_prev & cke_s;
  wire is_nop    = cs_n | (ras_n & cas_n & we_n);
  wire sel       = ~cs_n;
  wire is_act    = sel & ~ras_n & cas_n & we_n;
  wire is_pre    = sel & ~ras_n & cas_n & ~we_n;
  wire is_rd     = sel & ras_n & ~cas_n & we_n;
  wire is_wr     = sel & ras_n & ~cas_n & ~we_n;
  wire is_bst    = sel & ras_n & cas_n & ~we_n;
  wire is_ref    = sel & ~ras_n & ~cas_n & we_n;
  wire is_mrs    = sel & ~ras_n & ~cas_n & ~we_n;

  wire [3:0] idle_v;
  wire [3:0] ap_v;
  for (genvar g = 0; g < 4; g++) begin : g_flags
    assign idle_v[g] = (bank_st[g] == B_IDLE);
    assign ap_v[g]   = (bank_st[g] == B_RDAP) || (bank_st[g] == B_WRAP);
  end
  wire      all_idle = &idle_v;
  wire      ap_busy  = |ap_v;
  sdc_bst_t tgt_st;
  assign tgt_st = bank_st[ba];
  wire      tgt_open = (tgt_st == B_ROW) || (tgt_st == B_RD) || (tgt_st == B_WR);

  wire cmd_ok  = (gst == G_NORM) && both_high;
  wire ok_act  = cmd_ok & is_act & (tgt_st == B_IDLE);
  wire ok_rw   = cmd_ok & (is_rd | is_wr) & tgt_open & ~ap_busy;
  wire ok_pre  = cmd_ok & is_pre & ~ap_busy & (addr[AP_BIT] | tgt_st != B_ACTV);
  wire ok_bst  = cmd_ok & is_bst & b_on & ~b_ap;
  wire ok_ref  = cmd_ok & is_ref & all_idle;
  wire ok_mrs  = cmd_ok & is_mrs & all_idle;
  wire lowfall = (gst == G_NORM) & cke_prev & ~cke_s;
  wire sr_go   = lowfall & is_ref & all_idle;
  wire pd_go   = lowfall & is_nop & all_idle;
  wire norm_bad = cmd_ok & ~is_nop & ~(ok_act | ok_rw | ok_pre | ok_bst | ok_ref | ok_mrs);
  wire wait_bad = both_high & ~is_nop &
                  ((gst == G_MRS) | (gst == G_REF) | (gst == G_SREXIT));
  wire exit_bad = ((gst == G_SREF) | (gst == G_PDOWN)) & cke_s & ~is_nop;
  wire illegal  = norm_bad | wait_bad | exit_bad | (lowfall & ~is_nop & ~sr_go);

  ////////////////////////////////////////////////////////////////////////////
  // Burst address generation
  wire [2:0] bl_code = mode[MODE_BL_LSB +: 3];
  wire       il_mode = mode[MODE_BT_BIT];
  wire [2:0] cl_code = mode[MODE_CL_LSB +: 3];
  logic [7:0] new_len;
  always_comb begin
    unique case (bl_code)
      BL_1:    new_len = 8'h00;
      BL_2:    new_len = 8'h01;
      BL_4:    new_len = 8'h03;
      BL_8:    new_len = 8'h07;
      default: new_len = 8'hff;
    endcase
  end

  function automatic logic [7:0] burst_col(input logic [7:0] base, input logic [7:0] cnt,
                                           input logic [7:0] len, input logic il);
    logic [7:0] seq;
    seq = (base & ~len) | ((base + cnt) & len);
    // Interleave differs only at lengths 4 and 8                  
    if (il && (len == 8'h03 || len == 8'h07)) begin
      burst_col = base ^ cnt;
    end else begin
      burst_col = seq;
    end
  endfunction

  wire pre_hits = ok_pre & (addr[AP_BIT] | ba == b_bank);
  wire b_term   = b_on & (ok_rw | ok_bst | pre_hits);
  wire b_last   = b_on & clk_on & ~b_term & ~b_full & (b_cnt == b_len);
  wire start_rw = clk_on & ok_rw;
  wire go_word  = start_rw | (b_on & clk_on & ~b_term);
  wire word_rd  = start_rw ? is_rd : b_rd;
  wire [1:0] word_bank = start_rw ? ba : b_bank;
  wire [7:0] word_col  = start_rw ? addr[7:0] : burst_col(b_base, b_cnt, b_len, il_mode);
  wire [9:0] word_idx  = {word_bank, word_col};

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank next state
  wire [3:0] trcd_f = timing[TIM_TRCD_LSB +: 4];
  wire [3:0] trp_f  = timing[TIM_TRP_LSB +: 4];
  wire [7:0] refresh_recovery_time_f = timing[TIM_REFRESH_RECOVERY_TIME_LSB +: 8];
  sdc_bst_t   next_bank_st [4];
  logic [7:0] next_btmr    [4];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_bank_st[i] = bank_st[i];
      next_btmr[i]    = (clk_on && btmr[i] != 8'h00) ? btmr[i] - 8'h01 : btmr[i];
      if (bank_st[i] == B_ACTV && btmr[i] <= 8'h01 && clk_on) begin
        next_bank_st[i] = B_ROW;
      end
      if (bank_st[i] == B_PRE && btmr[i] <= 8'h01 && clk_on) begin
        next_bank_st[i] = B_IDLE;
      end
      if ((b_term || b_last) && b_bank == 2'(i)) begin
        next_bank_st[i] = (b_last && b_ap) ? B_PRE : B_ROW;
        next_btmr[i]    = {4'h0, trp_f};
      end
      if (ok_act && ba == 2'(i)) begin
        next_bank_st[i] = B_ACTV;
        next_btmr[i]    = {4'h0, trcd_f};
      end
      if (ok_rw && ba == 2'(i)) begin
        next_btmr[i] = {4'h0, trp_f};
        if (new_len == 8'h00) begin
          next_bank_st[i] = addr[AP_BIT] ? B_PRE : B_ROW;
        end else if (addr[AP_BIT]) begin
          next_bank_st[i] = is_rd ? B_RDAP : B_WRAP;
        end else begin
          next_bank_st[i] = is_rd ? B_RD : B_WR;
        end
      end
      if (ok_pre && (addr[AP_BIT] || ba == 2'(i)) &&
          (bank_st[i] == B_ROW || bank_st[i] == B_RD || bank_st[i] == B_WR)) begin
        next_bank_st[i] = B_PRE;
        next_btmr[i]    = {4'h0, trp_f};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        bank_st[i] <= B_IDLE;
        btmr[i]    <= 8'h00;
      end
    end else if (gst == G_NORM) begin
      bank_st <= next_bank_st;
      btmr    <= next_btmr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power, refresh and mode state
  sdc_gst_t   next_gst;
  logic [7:0] next_gtmr;
  always_comb begin
    next_gst  = gst;
    next_gtmr = (gtmr != 8'h00) ? gtmr - 8'h01 : gtmr;
    unique case (gst)
      G_NORM: begin
        if (sr_go) begin
          next_gst = G_SREF;
        end else if (pd_go) begin
          next_gst = G_PDOWN;
        end else if (ok_ref) begin
          next_gst  = G_REF;
          next_gtmr = refresh_recovery_time_f;
        end else if (ok_mrs) begin
          next_gst  = G_MRS;
          next_gtmr = MRS_HOLD_CYC;
        end
      end
      G_PDOWN: begin
        if (cke_s) begin
          next_gst = G_NORM;
        end
      end
      G_SREF: begin
        if (cke_s) begin
          next_gst  = G_SREXIT;
          next_gtmr = refresh_recovery_time_f;
        end
      end
      G_SREXIT, G_MRS, G_REF: begin
        if (gtmr <= 8'h01) begin
          next_gst = G_NORM;
        end
      end
      default: next_gst = G_NORM;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gst      <= G_NORM;
      gtmr     <= 8'h00;
      cke_prev <= 1'b0;
      mode     <= MODE_RST;
    end else begin
      gst      <= next_gst;
      gtmr     <= next_gtmr;
      cke_prev <= cke_s;
      if (ok_mrs) begin
        mode <= addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_on   <= 1'b0;
      b_rd   <= 1'b0;
      b_ap   <= 1'b0;
      b_bank <= 2'h0;
      b_base <= 8'h00;
      b_cnt  <= 8'h00;
      b_len  <= 8'h00;
      b_full <= 1'b0;
    end else if (start_rw) begin
      b_on   <= (new_len != 8'h00);
      b_rd   <= is_rd;
      b_ap   <= addr[AP_BIT];
      b_bank <= ba;
      b_base <= addr[7:0];
      b_cnt  <= 8'h01;
      b_len  <= new_len;
      b_full <= (bl_code == BL_FULL);
    end else if (b_term || b_last) begin
      b_on <= 1'b0;
    end else if (b_on && clk_on) begin
      b_cnt <= b_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data store and read pipeline
  always_ff @(posedge aclk) begin
    if (go_word && !word_rd && !dqm_s) begin
      mem[word_idx] <= dq_s;
    end
  end

  // Words fetched before a stop still drain, giving latency minus one words
  wire [15:0] out_data  = (cl_code == CL_3) ? pd[1] : pd[0];
  wire        out_valid = (cl_code == CL_3) ? pv[1] : pv[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pv       <= 2'b00;
      pd[0]    <= 16'h0000;
      pd[1]    <= 16'h0000;
      dqm_d1   <= 1'b0;
      sd_dq_o  <= 16'h0000;
      sd_dq_oe <= 1'b0;
    end else if (gst == G_SREF || gst == G_SREXIT) begin
      pv       <= 2'b00;
      sd_dq_oe <= 1'b0;
    end else if (clk_on) begin
      pv       <= {pv[0], go_word & word_rd};
      pd[0]    <= mem[word_idx];
      pd[1]    <= pd[0];
      dqm_d1   <= dqm_s;
      sd_dq_o  <= out_data;
      sd_dq_oe <= out_valid & ~dqm_d1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_wr      = aw_hold & w_hold & ~s_axi_bvalid;
  wire wr_timing  = do_wr & (aw_addr == ADDR_TIMING);
  wire wr_error   = do_wr & (aw_addr == ADDR_ERROR);
  wire wr_mapped  = (aw_addr == ADDR_MODE) | (aw_addr == ADDR_STATUS) | wr_timing | wr_error;

  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[2:0] = gst;
    status_w[ST_BURST_BIT] = b_on;
    status_w[ST_SUSP_BIT]  = ~cke_prev;
    for (int i = 0; i < 4; i++) begin
      status_w[ST_BANK_LSB + 3*i +: 3] = bank_st[i];
    end
  end
  wire ar_mode = (s_axi_araddr == ADDR_MODE);
  wire ar_stat = (s_axi_araddr == ADDR_STATUS);
  wire ar_tim  = (s_axi_araddr == ADDR_TIMING);
  wire ar_err  = (s_axi_araddr == ADDR_ERROR);
  wire [31:0] rd_word = ar_mode ? {20'h0_0000, mode} :
                        ar_stat ? status_w :
                        ar_tim  ? {16'h0000, timing} :
                        ar_err  ? {16'h0000, err_cnt} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      timing       <= {REFRESH_RECOVERY_TIME_CYC, TRP_CYC, TRCD_CYC};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      for (int b = 0; b < 2; b++) begin
        if (wr_timing && w_strb[b]) begin
          timing[8*b +: 8] <= w_data[8*b +: 8];
        end
      end
    end
  end

  // Counter of refused commands; a new one wins over a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_cnt <= 16'h0000;
    end else if (illegal) begin
      err_cnt <= wr_error ? 16'h0001 : err_cnt + 16'h0001;
    end else if (wr_error) begin
      err_cnt <= 16'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (ar_mode | ar_stat | ar_tim | ar_err) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* verif/sdc_core_props.sv */
// Port checker for the SDRAM command core.
// Assumes one clock domain; bound to every sdc_core.
`timescale 1ns/1ps
module sdc_core_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Memory pins
  input wire logic        sd_dqm,
  input wire logic        sd_dq_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  reset_quiet_a: assert property ($rose(aresetn) |->
    !sd_dq_oe && !s_axi_rvalid && !s_axi_bvalid) else $error("outputs live after reset");
  dqm_mask_a: assert property (sd_dqm ##1 sd_dqm |-> ##3 !sd_dq_oe)
    else $error("masked read word driven");
endmodule
bind sdc_core sdc_core_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sd_dqm, .sd_dq_oe);

/* verif/sdc_ctl_model.sv */
// Memory controller model driving the core's pins.
// Assumes the bench calls its tasks one after another.
`timescale 1ns/1ps
module sdc_ctl_model (
  // Clock
  input wire logic         aclk,
  // Pins
  output logic             cke,
  output logic [3:0]       cmd,
  output logic [1:0]       ba,
  output logic [11:0]      addr,
  output logic             dqm,
  output logic [15:0]      dq,
  input wire logic [15:0]  dq_o,
  input wire logic         dq_oe
);
  logic [15:0] rd_q[$];
  initial begin
    cke = 1'b1;
    cmd = 4'h7;
    ba = 2'h0;
    addr = 12'h000;
    dqm = 1'b0;
    dq = 16'h0000;
  end
  // One command per cycle; the bench sets the order, refused commands included
  task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a, input logic m, input logic [15:0] d);
    @(posedge aclk);
    cke <= k;
    cmd <= c;
    ba <= b;
    addr <= a;
    dqm <= m;
    dq <= d;
  endtask
  // Released data bus toggles so stale words never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge aclk);
      cmd <= 4'h7;
      dqm <= 1'b0;
      dq <= ~dq;
    end
  endtask
  always @(posedge aclk) if (dq_oe === 1'b1) rd_q.push_back(dq_o);
endmodule

/* verif/tb.sv */
// Self-checking bench for sdc_core.
// Assumes the controller model and the port checker sit beside it.
`timescale 1ns/1ps
module tb;
  import sdc_pkg::*;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] BST = 4'h6, PRE = 4'h2, REF = 4'h1, MRS = 4'h0;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, cke, dqm, oe;
  logic [3:0] cmd;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [15:0] dq, dq_o;
  int errors = 0, checks_done = 0;
  always #12.5 aclk = ~aclk;
  sdc_core u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sd_cke(cke), .sd_cs_n(cmd[3]), .sd_ras_n(cmd[2]), .sd_cas_n(cmd[1]), .sd_we_n(cmd[0]),
    .sd_ba(ba), .sd_addr(addr), .sd_dqm(dqm), .sd_dq_i(dq), .sd_dq_o(dq_o), .sd_dq_oe(oe));
  sdc_ctl_model u_ctl (.aclk, .cke, .cmd, .ba, .addr, .dqm, .dq, .dq_o, .dq_oe(oe));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Each channel is released at the edge that takes it; answers are taken at their edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk) {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, s, 3'b111};
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic wr4(input logic [15:0] base, input logic [3:0] m);
    for (int i = 0; i < 4; i++) u_ctl.issue(1'b1, i ? NOP : WR, 2'h0, 12'h0, m[i], base + 16'(i));
    u_ctl.idle(2);
  endtask
  task automatic rd_chk(input int n, input logic [15:0] w0, w1, input string what);
    u_ctl.idle(10);
    chk(32'(u_ctl.rd_q.size()), 32'(n), what);
    chk({16'h0, u_ctl.rd_q[0]}, {16'h0, w0}, what);
    chk({16'h0, u_ctl.rd_q[1]}, {16'h0, w1}, what);
    u_ctl.rd_q.delete();
  endtask
  task automatic st_chk(input logic [31:0] e);
    axi_rd(ADDR_STATUS);
    chk(d & 32'h7, e, "state");
  endtask
  // Masked read cut by a write, write cut by burst stop, write cut by precharge
  task automatic t_cut_wr;
    u_ctl.issue(1'b1, RD, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b1, 16'h0);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b1, 16'h0);
    u_ctl.issue(1'b1, WR, 2'h0, 12'h0, 1'b0, 16'h50);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b0, 16'h51);
    u_ctl.issue(1'b1, BST, 2'h0, 12'h0, 1'b0, 16'h52);
    u_ctl.issue(1'b1, WR, 2'h0, 12'h0, 1'b0, 16'h60);
    u_ctl.issue(1'b1, PRE, 2'h0, 12'h0, 1'b1, 16'h61);
    u_ctl.idle(3);
    u_ctl.issue(1'b1, ACT, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(4);
    u_ctl.issue(1'b1, RD, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(10);
    chk({16'h0, u_ctl.rd_q[2]}, 32'h51, "precharge cut");
    chk({16'h0, u_ctl.rd_q[3]}, 32'h22, "stop cut");
    rd_chk(5, 16'h20, 16'h60, "read cut by write");
  endtask
  // Nothing is issued while the auto-precharge burst runs
  task automatic t_ap_rd;
    u_ctl.issue(1'b1, RD, 2'h0, 12'h400, 1'b0, 16'h0);
    rd_chk(4, 16'h60, 16'h51, "auto precharge read");
    axi_rd(ADDR_STATUS);
    chk({29'h0, d[ST_BANK_LSB +: 3]}, 32'(B_IDLE), "auto precharge idle");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    u_ctl.idle(4);
    axi_rd(ADDR_TIMING);
    chk(d, 32'h311, "timing");
    axi_wr(ADDR_TIMING, 32'hffff_0422, 4'h1);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "timing write");
    axi_rd(ADDR_TIMING);
    chk(d, 32'h322, "timing strobe");
    axi_wr(8'h10, 32'h0, 4'hf);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(8'h10);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
    u_ctl.issue(1'b1, MRS, 2'h0, 12'h022, 1'b0, 16'h0);
    u_ctl.issue(1'b1, ACT, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(4);
    axi_rd(ADDR_MODE);
    chk(d, 32'h022, "mode");
    axi_rd(ADDR_ERROR);
    chk(d, 32'h1, "refused");
    axi_wr(ADDR_ERROR, 32'h0, 4'hf);
    u_ctl.issue(1'b1, RD, 2'h1, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(3);
    axi_rd(ADDR_ERROR);
    chk(d, 32'h1, "idle bank read");
    u_ctl.issue(1'b1, ACT, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(3);
    wr4(16'h10, 4'h0);
    wr4(16'h20, 4'b0010);
    u_ctl.rd_q.delete();
    u_ctl.issue(1'b1, RD, 2'h0, 12'h0, 1'b0, 16'h0);
    rd_chk(4, 16'h20, 16'h11, "masked write");
    u_ctl.issue(1'b1, RD, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b1, 16'h0);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b1, 16'h0);
    rd_chk(2, 16'h20, 16'h23, "masked read");
    u_ctl.issue(1'b1, RD, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.issue(1'b1, BST, 2'h0, 12'h0, 1'b0, 16'h0);
    rd_chk(2, 16'h20, 16'h11, "burst stop");
    u_ctl.issue(1'b1, RD, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.issue(1'b1, RD, 2'h0, 12'h2, 1'b0, 16'h0);
    rd_chk(5, 16'h20, 16'h22, "column cut");
    t_cut_wr();
    t_ap_rd();
    u_ctl.issue(1'b1, PRE, 2'h0, 12'h400, 1'b0, 16'h0);
    u_ctl.idle(4);
    u_ctl.issue(1'b1, REF, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(8);
    st_chk(32'h0);
    u_ctl.issue(1'b0, REF, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(4);
    st_chk(32'h2);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(10);
    st_chk(32'h0);
    u_ctl.issue(1'b0, NOP, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(4);
    st_chk(32'h1);
    u_ctl.issue(1'b1, NOP, 2'h0, 12'h0, 1'b0, 16'h0);
    u_ctl.idle(6);
    st_chk(32'h0);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    close_out();
  end
endmodule
